// ### ocfr_pkg.sv
package ocfr_pkg;

  // command codes of the three registers
  localparam logic [7:0] OCFR_CMD_OC_WARN   = 8'h4A;
  localparam logic [7:0] OCFR_CMD_UC_FAULT  = 8'h4B;
  localparam logic [7:0] OCFR_CMD_UC_ACTION = 8'h4C;

  // reset values
  localparam logic [15:0] OCFR_OC_WARN_RST   = 16'h0000;
  localparam logic [15:0] OCFR_UC_FAULT_RST  = 16'h0000;
  localparam logic [7:0]  OCFR_UC_ACTION_RST = 8'h00;

  // action byte field positions
  localparam int OCFR_RESP_HI  = 7;
  localparam int OCFR_RESP_LO  = 6;
  localparam int OCFR_RETRY_HI = 5;
  localparam int OCFR_RETRY_LO = 3;
  localparam int OCFR_DELAY_HI = 2;
  localparam int OCFR_DELAY_LO = 0;
  // linear format: mantissa in low eleven bits
  localparam int OCFR_MANT_HI  = 10;

  // response modes and special retry codes
  localparam logic [1:0] OCFR_RESP_IGNORE   = 2'h0;
  localparam logic [1:0] OCFR_RESP_CONTINUE = 2'h1;
  localparam logic [1:0] OCFR_RESP_RETRY    = 2'h2;
  localparam logic [1:0] OCFR_RESP_RESUME   = 2'h3;
  localparam logic [2:0] OCFR_RETRY_NONE    = 3'h0;
  localparam logic [2:0] OCFR_RETRY_FOREVER = 3'h7;

  // timing
  localparam int OCFR_CLK_PERIOD_NS = 20;
  localparam int OCFR_CONT_UNIT_US  = 10000;
  localparam int OCFR_RETRY_UNIT_US = 8200;
  localparam int OCFR_CONT_UNIT_CYC =
    OCFR_CONT_UNIT_US * 1000 / OCFR_CLK_PERIOD_NS;
  localparam int OCFR_RETRY_UNIT_CYC =
    OCFR_RETRY_UNIT_US * 1000 / OCFR_CLK_PERIOD_NS;

  // register access port of the management bus engine
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  code;
    logic [15:0] data;
  } ocfr_cmd_t;

  typedef struct packed {
    logic        valid;
    logic        hit;
    logic [15:0] data;
  } ocfr_rsp_t;

endpackage

// ### ocfr_unit_ticker.sv
`timescale 1ns/1ns
`default_nettype none
module ocfr_unit_ticker #(
  parameter int unsigned PERIOD = 2
) (
  input  wire logic ref_clk,
  input  wire logic reset_n,
  input  wire logic restart,
  output logic      tick
);
  localparam int W = (PERIOD > 2) ? $clog2(PERIOD) : 1;
  localparam logic [W-1:0] LAST = W'(PERIOD - 1);

  logic [W-1:0] cnt;
  wire          at_last = (cnt == LAST);

  // free count of one unit, realigned by restart
  always_ff @(posedge ref_clk) begin
    if (!reset_n || restart || at_last) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + W'(1);
    end
  end

  // one-cycle enable on the last cycle of each unit; not registered so
  // the caller can decide on the very edge that completes the unit
  assign tick = at_last;
endmodule
`default_nettype wire

// ### ocfr_fault_response.sv
`timescale 1ns/1ns
`default_nettype none
module ocfr_fault_response
  import ocfr_pkg::*;
#(
  parameter int unsigned CONT_UNIT_CYC  = OCFR_CONT_UNIT_CYC,
  parameter int unsigned RETRY_UNIT_CYC = OCFR_RETRY_UNIT_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire ocfr_cmd_t   cmd,
  input  wire logic        clear_faults,
  input  wire logic [15:0] output_current,
  input  wire logic        output_request,
  input  wire logic        other_fault_shutdown,
  output ocfr_rsp_t        rsp,
  output logic             output_enable,
  output logic             alert_line_out,
  output logic             alert_line_oe,
  output logic             uc_fault_flag,
  output logic             oc_warn_flag
);

  typedef enum logic [2:0] {
    ST_RUN,
    ST_CONT,
    ST_WAIT,
    ST_TRY,
    ST_LATCH,
    ST_HOLD
  } ocfr_state_t;

  ocfr_state_t state;
  ocfr_state_t next_state;

  logic [15:0] over_current_warning_threshold;
  logic [15:0] under_current_fault_threshold;
  logic [7:0]  under_current_fault_action;
  logic [2:0]  units_done;
  logic [2:0]  attempts;
  logic [2:0]  next_attempts;
  logic        timer_restart;
  logic        cont_tick;
  logic        retry_tick;

  // register write decode
  wire wr_oc  = cmd.wr && (cmd.code == OCFR_CMD_OC_WARN);
  wire wr_uc  = cmd.wr && (cmd.code == OCFR_CMD_UC_FAULT);
  wire wr_act = cmd.wr && (cmd.code == OCFR_CMD_UC_ACTION);
  wire rd_hit = (cmd.code == OCFR_CMD_OC_WARN) ||
                (cmd.code == OCFR_CMD_UC_FAULT) ||
                (cmd.code == OCFR_CMD_UC_ACTION);

  // read data select, unmapped codes read zero
  wire [15:0] rd_mux =
    (cmd.code == OCFR_CMD_OC_WARN)   ? over_current_warning_threshold :
    (cmd.code == OCFR_CMD_UC_FAULT)  ? under_current_fault_threshold :
    (cmd.code == OCFR_CMD_UC_ACTION) ? {8'h00, under_current_fault_action} :
                                       16'h0000;

  // action byte fields
  // standard response layout
  wire [1:0] resp  = under_current_fault_action[OCFR_RESP_HI:OCFR_RESP_LO];
  wire [2:0] retry = under_current_fault_action[OCFR_RETRY_HI:OCFR_RETRY_LO];
  wire [2:0] delay = under_current_fault_action[OCFR_DELAY_HI:OCFR_DELAY_LO];

  // both thresholds share the measurement exponent; compare mantissas
  // limitation: exponents are not compared; a threshold written with a
  // different exponent than the measurement gives a wrong decision
  wire signed [10:0] cur_m  = output_current[OCFR_MANT_HI:0];
  wire signed [10:0] warn_m =
    over_current_warning_threshold[OCFR_MANT_HI:0];
  wire signed [10:0] uc_m   =
    under_current_fault_threshold[OCFR_MANT_HI:0];
  wire oc_seen = cur_m > warn_m;
  wire uc_seen = cur_m < uc_m;

  wire retry_exhausted = (retry != OCFR_RETRY_FOREVER) && (attempts == retry);
  // output states are judged on the next state so output_enable lands
  // on the same edge as the decision, one cycle after the fault is seen
  wire out_state = (next_state == ST_RUN) || (next_state == ST_CONT) ||
                   (next_state == ST_TRY);

  // both unit timers realign on every timer restart, so a unit always
  // counts whole from the restart edge, never from a stale phase
  // continue-operating unit ticker
  ocfr_unit_ticker #(
    .PERIOD (CONT_UNIT_CYC)
  ) u_cont_unit (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .restart (timer_restart),
    .tick    (cont_tick)
  );

  ocfr_unit_ticker #(
    .PERIOD (RETRY_UNIT_CYC)
  ) u_retry_unit (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .restart (timer_restart),
    .tick    (retry_tick)
  );

  wire unit_tick = (state == ST_CONT) ? cont_tick : retry_tick;

  // delay as plain count
  // looks ahead on the unit's last cycle, so the decision edge is the one
  // where the count reaches the delay; otherwise every interval would run
  // long and attempt spacing would drift from delay times unit
  wire unit_last = unit_tick && (units_done + 3'h1 == delay);
  wire expired   = (units_done == delay) || unit_last;

  // response sequencer; a host disable always ends retrying
  always_comb begin
    next_state    = state;
    next_attempts = attempts;
    timer_restart = 1'b0;
    if (other_fault_shutdown) begin
      next_state = ST_LATCH;
    end else if (!output_request && state != ST_LATCH) begin
      // commanding the output off stops retries
      next_state = ST_RUN;
    end else begin
      unique case (state)
        ST_RUN: begin
          if (uc_seen) begin
            unique case (resp)
              OCFR_RESP_IGNORE: next_state = ST_RUN;
              OCFR_RESP_CONTINUE: begin
                next_state    = ST_CONT;
                timer_restart = 1'b1;
              end
              OCFR_RESP_RETRY: begin
                next_attempts = 3'h0;
                timer_restart = 1'b1;
                next_state = (retry == OCFR_RETRY_NONE) ? ST_LATCH : ST_WAIT;
              end
              OCFR_RESP_RESUME: next_state = ST_HOLD;
            endcase
          end
        end
        ST_CONT: begin
          if (expired) begin
            timer_restart = 1'b1;
            next_attempts = 3'h0;
            // fault still present acts per retry field
            if (!uc_seen) begin
              next_state = ST_RUN;
            end else if (retry == OCFR_RETRY_NONE) begin
              next_state = ST_LATCH;
            end else begin
              next_state = ST_WAIT;
            end
          end
        end
        ST_WAIT: begin
          if (expired) begin
            // latch off once attempts run out
            if (retry_exhausted) begin
              next_state = ST_LATCH;
            end else begin
              // each attempt restarts the spacing timer
              next_state    = ST_TRY;
              next_attempts = attempts + 3'h1;
              timer_restart = 1'b1;
            end
          end
        end
        ST_TRY: begin
          // a failed attempt goes off but keeps the attempt's timer
          if (uc_seen) begin
            next_state = ST_WAIT;
          end else if (expired) begin
            next_state = ST_RUN;
          end
        end
        ST_LATCH: begin
          // only a fault clear restores the output
          if (clear_faults) begin
            next_state = ST_RUN;
          end
        end
        ST_HOLD: begin
          if (!uc_seen) begin
            next_state = ST_RUN;
          end
        end
        default: next_state = ST_LATCH;
      endcase
    end
  end

  // state and attempt count
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state    <= ST_RUN;
      attempts <= 3'h0;
    end else begin
      state    <= next_state;
      attempts <= next_attempts;
    end
  end

  // elapsed units since the last timer restart; saturates at seven
  always_ff @(posedge ref_clk) begin
    if (!reset_n || timer_restart) begin
      units_done <= 3'h0;
    end else if (unit_tick && units_done != 3'h7) begin
      units_done <= units_done + 3'h1;
    end
  end

  // threshold and action registers
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      over_current_warning_threshold <= OCFR_OC_WARN_RST;
      under_current_fault_threshold  <= OCFR_UC_FAULT_RST;
      under_current_fault_action     <= OCFR_UC_ACTION_RST;
    end else begin
      if (wr_oc) over_current_warning_threshold <= cmd.data;
      if (wr_uc) under_current_fault_threshold <= cmd.data;
      if (wr_act) under_current_fault_action <= cmd.data[7:0];
    end
  end

  // sticky flags; a detection in the clear cycle wins over the clear
  // flag and alert on every under-current fault
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      uc_fault_flag  <= 1'b0;
      oc_warn_flag   <= 1'b0;
      alert_line_oe  <= 1'b0;
    end else begin
      uc_fault_flag <= uc_seen || (uc_fault_flag && !clear_faults);
      oc_warn_flag  <= oc_seen || (oc_warn_flag && !clear_faults);
      alert_line_oe <= uc_seen || oc_seen ||
                       ((uc_fault_flag || oc_warn_flag) && !clear_faults);
    end
  end

  // open-drain alert only ever drives low
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      alert_line_out <= 1'b0;
      output_enable  <= 1'b0;
    end else begin
      alert_line_out <= 1'b0;
      output_enable  <= output_request && out_state;
    end
  end

  // read answer one cycle after the request
  // idle cycles answer zero so a stale word never looks like an answer
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      rsp <= '0;
    end else begin
      rsp.valid <= cmd.rd;
      rsp.hit   <= cmd.rd && rd_hit;
      rsp.data  <= cmd.rd ? rd_mux : 16'h0000;
    end
  end

endmodule
`default_nettype wire

// ### ocfr_fault_response_asserts.sv
`timescale 1ns/1ns
`default_nettype none
// watches register answers and the fault outputs
module ocfr_fault_response_asserts
  import ocfr_pkg::*;
#(
  parameter int unsigned CONT_UNIT_CYC  = OCFR_CONT_UNIT_CYC,
  parameter int unsigned RETRY_UNIT_CYC = OCFR_RETRY_UNIT_CYC
) (
  input wire logic        ref_clk,
  input wire logic        reset_n,
  input wire ocfr_cmd_t   cmd,
  input wire logic        clear_faults,
  input wire logic [15:0] output_current,
  input wire logic        output_request,
  input wire logic        other_fault_shutdown,
  input wire ocfr_rsp_t   rsp,
  input wire logic        output_enable,
  input wire logic        alert_line_out,
  input wire logic        alert_line_oe,
  input wire logic        uc_fault_flag,
  input wire logic        oc_warn_flag
);
  logic [1:0] resp;
  wire        hit;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // the three mapped codes are consecutive
  assign hit = cmd.code >= OCFR_CMD_OC_WARN
            && cmd.code <= OCFR_CMD_UC_ACTION;
  // shadow of the response field, same write path as the block
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      resp <= 2'h0;
    end else if (cmd.wr && cmd.code == OCFR_CMD_UC_ACTION) begin
      resp <= cmd.data[OCFR_RESP_HI:OCFR_RESP_LO];
    end
  end
  a_read_mapped: assert property (
    cmd.rd && hit |=> rsp.valid && rsp.hit) else $error("no read answer");
  a_read_unmapped: assert property (
    cmd.rd && !hit |=> rsp.valid && !rsp.hit && rsp.data == 16'h0000)
    else $error("unmapped read answered");
  a_no_stray: assert property (
    !cmd.rd |=> !rsp.valid) else $error("answer without read");
  a_alert_raise: assert property (
    $rose(uc_fault_flag) |-> alert_line_oe) else $error("alert not pulled");
  a_alert_drain: assert property (
    alert_line_out == 1'b0) else $error("alert driven high");
  a_flag_sticky: assert property (
    uc_fault_flag && !clear_faults |=> uc_fault_flag)
    else $error("fault flag lost");
  a_ignore_runs: assert property (
    resp == OCFR_RESP_IGNORE && output_enable && output_request
    && !other_fault_shutdown && !cmd.wr |=> output_enable)
    else $error("output dropped in ignore mode");
  a_disable_now: assert property (
    resp == OCFR_RESP_RETRY && $rose(uc_fault_flag) |-> ##[0:1]
    !output_enable) else $error("output not disabled");
  a_warn_sticky: assert property (
    oc_warn_flag && !clear_faults |=> oc_warn_flag)
    else $error("warning flag lost");
  a_other_shut: assert property (
    other_fault_shutdown |=> !output_enable)
    else $error("output kept on after shutdown");
endmodule
bind ocfr_fault_response ocfr_fault_response_asserts #(
  .CONT_UNIT_CYC(CONT_UNIT_CYC), .RETRY_UNIT_CYC(RETRY_UNIT_CYC)) i_chk (
  .ref_clk(ref_clk), .reset_n(reset_n), .cmd(cmd),
  .clear_faults(clear_faults), .output_current(output_current),
  .output_request(output_request), .rsp(rsp),
  .other_fault_shutdown(other_fault_shutdown),
  .output_enable(output_enable), .alert_line_out(alert_line_out),
  .alert_line_oe(alert_line_oe), .uc_fault_flag(uc_fault_flag),
  .oc_warn_flag(oc_warn_flag));
`default_nettype wire

// ### ocfr_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// management bus host: one-cycle strobes
module ocfr_host_model
  import ocfr_pkg::*;
(
  input  wire logic ref_clk,
  output ocfr_cmd_t cmd,
  output logic      clear_faults
);
  initial begin
    cmd = '0;
    clear_faults = 1'b0;
  end
  // idle code and data show the inverse, never the last value
  task automatic access(input logic w, input logic [7:0] c,
                        input logic [15:0] d);
    @(posedge ref_clk);
    #1;
    cmd = '{w, !w, c, d};
    @(posedge ref_clk);
    #1;
    cmd = '{1'b0, 1'b0, ~c, ~d};
  endtask
  task automatic clear();
    @(posedge ref_clk);
    #1;
    clear_faults = 1'b1;
    @(posedge ref_clk);
    #1;
    clear_faults = 1'b0;
  endtask
endmodule
`default_nettype wire

// ### output_current_fault_response_tb.sv
`timescale 1ns/1ns
`default_nettype none
module output_current_fault_response_tb;
  import ocfr_pkg::*;
  localparam int RU = 6;
  ocfr_cmd_t   cmd;
  ocfr_rsp_t   rsp;
  logic        ref_clk;
  logic        reset_n;
  logic        clear_faults;
  logic [15:0] cur;
  logic        req;
  logic        ofs;
  logic        oe;
  logic        a_out;
  logic        a_oe;
  logic        uc_f;
  logic        oc_f;
  logic [15:0] regv [3];
  logic [16:0] exp_q [$];
  int          bad_count = 0;
  int          check_count = 0;
  int          cycles = 0;

  ocfr_fault_response #(.CONT_UNIT_CYC(8), .RETRY_UNIT_CYC(RU)) i_dut (
    .ref_clk(ref_clk), .reset_n(reset_n), .cmd(cmd), .rsp(rsp),
    .clear_faults(clear_faults), .output_current(cur),
    .output_request(req), .other_fault_shutdown(ofs),
    .output_enable(oe), .alert_line_out(a_out), .alert_line_oe(a_oe),
    .uc_fault_flag(uc_f), .oc_warn_flag(oc_f));
  ocfr_host_model i_host (.ref_clk(ref_clk), .cmd(cmd),
                          .clear_faults(clear_faults));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk_lvl(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t level %b want %b", $time, got, exp);
    end
  endtask
  task automatic chk_rd(input logic [16:0] got, input logic [16:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t read %h want %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic rd(input logic [7:0] c, input logic [16:0] e);
    exp_q.push_back(e);
    i_host.access(1'b0, c, 16'h0000);
  endtask
  // clear on a healthy current, set the action, then apply the current
  task automatic fault(input logic [7:0] act, input logic [15:0] c);
    cur = 16'h0096;
    i_host.clear();
    i_host.access(1'b1, OCFR_CMD_UC_ACTION, {8'h00, act});
    cur = c;
  endtask

  // oldest note meets each answer; also the hang limit
  always @(posedge ref_clk) begin
    cycles++;
    if (rsp.valid === 1'b1 && exp_q.size() > 0) begin
      chk_rd({rsp.hit, rsp.data}, exp_q.pop_front());
    end else if (rsp.valid === 1'b1) begin
      bad_count++;
      $display("BAD %0t answer without read", $time);
    end
    if (cycles == 5000) begin
      bad_count++;
      $display("BAD %0t timeout", $time);
      stop_test();
    end
  end

  initial begin
    int n;
    int rises;
    int t0;
    int t1;
    logic last;
    reset_n = 1'b0;
    cur = 16'h0000;
    req = 1'b0;
    ofs = 1'b0;
    t1 = 0;
    void'($urandom(91));
    tick(2);
    reset_n = 1'b1;
    // zero after reset, then a random round trip per register
    for (int i = 0; i < 3; i++) begin
      rd(8'(OCFR_CMD_OC_WARN + i), 17'h10000);
      regv[i] = 16'($urandom);
      i_host.access(1'b1, 8'(OCFR_CMD_OC_WARN + i), regv[i]);
      rd(8'(OCFR_CMD_OC_WARN + i),
         {1'b1, i == 2 ? {8'h00, regv[i][7:0]} : regv[i]});
    end
    rd(8'h4D, 17'h00000);
    tick(3);
    $display("test registers done");
    i_host.access(1'b1, OCFR_CMD_OC_WARN, 16'h00C8);
    i_host.access(1'b1, OCFR_CMD_UC_FAULT, 16'h0064);
    // the random action byte must not steer the first output request
    i_host.access(1'b1, OCFR_CMD_UC_ACTION, 16'h0000);
    req = 1'b1;
    fault(8'h00, 16'h00FA);
    tick(3);
    chk_lvl(oc_f, 1'b1);
    fault(8'h00, 16'h0032);
    tick(20);
    chk_lvl(oe, 1'b1);
    chk_lvl(uc_f & a_oe & ~a_out, 1'b1);
    $display("test ignore done");
    fault(8'hC0, 16'h0032);
    tick(4);
    chk_lvl(oe, 1'b0);
    cur = 16'h0096;
    tick(4);
    chk_lvl(oe & uc_f, 1'b1);
    $display("test resume done");
    fault(8'h42, 16'h0032);
    tick(15);
    chk_lvl(oe, 1'b1);
    tick(4);
    chk_lvl(oe, 1'b0);
    $display("test continue done");
    // every retry code, attempts two units apart
    for (n = 0; n < 8; n++) begin
      fault({OCFR_RESP_RETRY, 3'(n), 3'h2}, 16'h0032);
      rises = 0;
      last = 1'b1;
      repeat (126) begin
        tick(1);
        if (oe === 1'b1 && last === 1'b0) begin
          rises++;
          t0 = t1;
          t1 = cycles;
        end
        last = oe;
      end
      chk_lvl(n == 7 ? rises > 6 : rises == n, 1'b1);
      if (n > 1) begin
        chk_lvl(t1 - t0 inside {[2*RU-1:2*RU+1]}, 1'b1);
      end
      cur = 16'h0096;
      tick(30);
      chk_lvl(oe, n == 7);
    end
    $display("test retries done");
    // another fault latches the running output off; only a clear restores output
    ofs = 1'b1;
    tick(1);
    ofs = 1'b0;
    tick(30);
    chk_lvl(oe, 1'b0);
    i_host.clear();
    tick(4);
    chk_lvl(oe, 1'b1);
    $display("test shutdown done");
    stop_test();
  end
endmodule
`default_nettype wire
